// file: logic/iop_pin_cell.sv
// one port pin: drive structure and input gating
`timescale 1ns/1ps
module iop_pin_cell
  import iop_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // control
  input  wire logic latch,
  input  wire logic push_pull,
  input  wire logic pin_in,
  // pin drive and sampled level
  output logic      pin_out,
  output logic      pin_oe,
  output logic      readable
);
  // open-drain high releases the pin; only then is the live level meaningful
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= latch;                 // see [R3]
      pin_oe  <= push_pull | ~latch;    // see [R2] see [R5]
    end
  end

  always_comb begin
    readable = (push_pull == 1'b0 && latch == 1'b1) ? pin_in : 1'b0; // see [R1] see [R4]
  end
endmodule

// file: logic/iop_pkg.sv
// constants and types shared by the i/o port control block
package iop_pkg;
  localparam int unsigned NIB_W        = 4;
  localparam int unsigned PD_W         = 10;
  localparam logic [3:0]  SD_LIMIT     = 4'hA;
  localparam logic [3:0]  TEST_LIMIT   = 4'h8;
  localparam int unsigned PD_EXT0_BIT  = 8;
  localparam int unsigned PD_EXT1_BIT  = 9;
  localparam int unsigned EXT_EDGE_BIT = 2;
  localparam int unsigned EXT_EN_BIT   = 3;
  localparam logic [3:0]  LATCH_RST    = 4'hF;
  localparam logic [9:0]  PD_LATCH_RST = 10'h3FF;
  localparam logic [3:0]  SEL_RST      = 4'h0;
  localparam logic [3:0]  EXTC_RST     = 4'h0;

  // instruction codes presented on the op port
  typedef enum logic [3:0] {
    IOP_OP_NONE,
    IOP_OP_RD_P0,
    IOP_OP_RD_P1,
    IOP_OP_RD_P2,
    IOP_OP_RD_P3,
    IOP_OP_RD_P4,
    IOP_OP_RD_PD,
    IOP_OP_WR_P0,
    IOP_OP_WR_P1,
    IOP_OP_WR_P2,
    IOP_OP_WR_P3,
    IOP_OP_WR_P4,
    IOP_OP_SET_D,
    IOP_OP_CLR_D,
    IOP_OP_TEST_D,
    IOP_OP_WR_PC
  } iop_op_t;
endpackage

// file: logic/iop_port_ctrl.sv
// general-purpose i/o port control with port d bit ops and ext0 edge flag
// Notes on behaviour
// [R1] open-drain, latch high: input reads pin
// [R2] open-drain, latch low: pin driven low
// [R3] push-pull: pin follows output latch
// [R4] ports 2/3 read pin only latch high
// [R5] ports 2/3 latch low drives low
// [R6] software keeps bit index in range
// [R7] d8/d9 output works with ext inputs
// [R8] d4-d6 readable during serial use
// [R9] d7 usable with timer1 event pin
// [R10] port c drives high with timer3
// [R11] software clears wakeup bit0 when ext0 off
// [R12] software clears wakeup bit2 when ext1 off
// [R13] ext0 edge change may set flag
// [R14] software waits before clearing ext0 flag
// [R15] per-pin structure, pull-up, wakeup select
// [R16] ports 0/1 structure per pin pair
// [R17] inputs sampled at execute, latches kept
`timescale 1ns/1ps
module iop_port_ctrl
  import iop_pkg::*;
#(
  parameter int unsigned NP = 4
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // instruction interface
  input  wire logic [3:0]        op,
  input  wire logic [NIB_W-1:0]  acc_in,
  input  wire logic [3:0]        bit_index,
  output logic [NIB_W-1:0]       acc_out,
  output logic                   acc_valid,
  output logic                   test_zero,
  // configuration
  input  wire logic [3:0]        port_drive_select_0,
  input  wire logic [3:0]        port_drive_select_1,
  input  wire logic [3:0]        port_drive_select_2,
  input  wire logic [3:0]        port_drive_select_3,
  input  wire logic [3:0]        ext0_control,
  input  wire logic              skip_clear_ext0_flag,
  input  wire logic [3:0]        pullup_select_0,
  input  wire logic [3:0]        pullup_select_1,
  // ports 0..4: in, out, enable
  input  wire logic [NP*4-1:0]   p_in,
  output logic [NP*4-1:0]        p_out,
  output logic [NP*4-1:0]        p_oe,
  output logic [3:0]             p4_out,
  output logic [3:0]             p4_oe,
  input  wire logic [3:0]        p4_in,
  // port d and port c
  input  wire logic [PD_W-1:0]   pd_in,
  output logic [PD_W-1:0]        pd_out,
  output logic [PD_W-1:0]        pd_oe,
  input  wire logic              pc_latch_in,
  output logic                   pc_out,
  output logic                   pc_oe,
  input  wire logic              timer3_wave,
  input  wire logic              timer3_out_sel,
  // pull-up enables and ext0 flag
  output logic [7:0]             pullup_en,
  output logic                   ext0_request_flag
);
  logic [3:0]      lat_reg [5];
  logic [PD_W-1:0] pd_lat_reg;
  logic            pc_lat_reg;
  logic [3:0]      rd_bits [5];
  logic [PD_W-1:0] pd_rd;
  logic [3:0]      sel [5];
  logic            ext0_sync_reg;
  logic            ext0_edge_reg;
  logic            ext0_hit;
  logic            lvl_mismatch;
  iop_op_t         opc;

  assign opc = iop_op_t'(op);

  // ports 0/1 share one select bit per pin pair; ports 2/3 are open drain only
  always_comb begin
    sel[0] = {port_drive_select_0[1], port_drive_select_0[1],
              port_drive_select_0[0], port_drive_select_0[0]};  // see [R16]
    sel[1] = {port_drive_select_0[3], port_drive_select_0[3],
              port_drive_select_0[2], port_drive_select_0[2]};  // see [R16]
    sel[2] = 4'h0;
    sel[3] = 4'h0;
    sel[4] = port_drive_select_2;                               // see [R15]
  end

  // output latches; reads never touch them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 5; i++) lat_reg[i] <= LATCH_RST;
    end else begin
      unique case (opc)
        IOP_OP_WR_P0: lat_reg[0] <= acc_in;
        IOP_OP_WR_P1: lat_reg[1] <= acc_in;
        IOP_OP_WR_P2: lat_reg[2] <= acc_in;
        IOP_OP_WR_P3: lat_reg[3] <= acc_in;
        IOP_OP_WR_P4: lat_reg[4] <= acc_in;
        default: ;                                              // see [R17]
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pd_lat_reg <= PD_LATCH_RST;
      pc_lat_reg <= 1'b0;
    end else begin
      if (opc == IOP_OP_SET_D && bit_index < SD_LIMIT)
        pd_lat_reg[bit_index] <= 1'b1;                          // see [R6]
      else if (opc == IOP_OP_CLR_D && bit_index < SD_LIMIT)
        pd_lat_reg[bit_index] <= 1'b0;                          // see [R6]
      if (opc == IOP_OP_WR_PC)
        pc_lat_reg <= pc_latch_in;
    end
  end

  genvar g, b;
  generate
    for (g = 0; g < 5; g++) begin : g_port
      for (b = 0; b < 4; b++) begin : g_bit
        logic po, poe, pin_lvl;
        iop_pin_cell u_cell (
          .clk       (clk),
          .reset     (reset),
          .latch     (lat_reg[g][b]),
          .push_pull (sel[g][b]),
          .pin_in    (pin_lvl),
          .pin_out   (po),
          .pin_oe    (poe),
          .readable  (rd_bits[g][b])
        );
        if (g == 4) begin : g_p4
          assign pin_lvl   = p4_in[b];
          assign p4_out[b] = po;
          assign p4_oe[b]  = poe;
        end else begin : g_pn
          assign pin_lvl      = p_in[g*4+b];
          assign p_out[g*4+b] = po;
          assign p_oe[g*4+b]  = poe;
        end
      end
    end
    // port d: d0-d3 per pin select, d4-d7 select nibble 3, d8/d9 open drain
    for (b = 0; b < PD_W; b++) begin : g_pd
      logic pp;
      if (b < 4) begin : g_lo
        assign pp = port_drive_select_1[b];                     // see [R15]
      end else if (b < 8) begin : g_mid
        assign pp = port_drive_select_3[b-4];
      end else begin : g_hi
        assign pp = 1'b0;
      end
      // serial, timer1 and ext functions leave the port paths intact
      iop_pin_cell u_cell (
        .clk       (clk),
        .reset     (reset),
        .latch     (pd_lat_reg[b]),                             // see [R7]
        .push_pull (pp),
        .pin_in    (pd_in[b]),                                  // see [R8] see [R9]
        .pin_out   (pd_out[b]),
        .pin_oe    (pd_oe[b]),
        .readable  (pd_rd[b])
      );
    end
  endgenerate

  // port c: timer3 output shares the pin, latch high still drives high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc_out <= 1'b0;
      pc_oe  <= 1'b0;
    end else begin
      pc_out <= pc_lat_reg | (timer3_out_sel & timer3_wave);   // see [R10]
      pc_oe  <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) pullup_en <= 8'h00;
    else       pullup_en <= {pullup_select_1, pullup_select_0}; // see [R15]
  end

  // input instructions sample in their own cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_out   <= 4'h0;
      acc_valid <= 1'b0;
      test_zero <= 1'b0;
    end else begin
      acc_valid <= 1'b0;
      test_zero <= 1'b0;
      unique case (opc)
        IOP_OP_RD_P0: begin acc_out <= rd_bits[0]; acc_valid <= 1'b1; end // see [R1]
        IOP_OP_RD_P1: begin acc_out <= rd_bits[1]; acc_valid <= 1'b1; end
        IOP_OP_RD_P2: begin acc_out <= rd_bits[2]; acc_valid <= 1'b1; end // see [R4]
        IOP_OP_RD_P3: begin acc_out <= rd_bits[3]; acc_valid <= 1'b1; end // see [R4]
        IOP_OP_RD_P4: begin acc_out <= rd_bits[4]; acc_valid <= 1'b1; end
        IOP_OP_RD_PD: begin acc_out <= pd_rd[3:0]; acc_valid <= 1'b1; end // see [R17]
        IOP_OP_TEST_D: begin
          if (bit_index < TEST_LIMIT)
            test_zero <= ~pd_rd[bit_index[2:0]];                // see [R6]
        end
        default: ;
      endcase
    end
  end

  // ext0 flag: only an edge into the selected polarity sets it, a held level does not;
  // changing the polarity bit can itself look like an edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext0_sync_reg <= 1'b0;
      ext0_edge_reg <= 1'b0;
    end else begin
      ext0_sync_reg <= pd_in[PD_EXT0_BIT];
      ext0_edge_reg <= ext0_sync_reg ^ ext0_control[EXT_EDGE_BIT];
    end
  end

  assign lvl_mismatch = ext0_sync_reg ^ ext0_control[EXT_EDGE_BIT];
  assign ext0_hit = ext0_control[EXT_EN_BIT] & lvl_mismatch & ~ext0_edge_reg; // see [R13]

  always_ff @(posedge clk or posedge reset) begin
    if (reset) ext0_request_flag <= 1'b0;
    else if (ext0_hit) ext0_request_flag <= 1'b1;               // set wins, see [R14]
    else if (skip_clear_ext0_flag) ext0_request_flag <= 1'b0;
  end
endmodule

// file: tb/iop_board.sv
// board model: pull-ups and external drivers on the port pins
`timescale 1ns/1ps
module iop_board (
  // device drive
  input  logic [29:0] dev_out,
  input  logic [29:0] dev_oe,
  // board drivers
  input  logic [29:0] ext_en,
  input  logic [29:0] ext_val,
  // resolved levels
  output logic [29:0] pin
);
  // device drive wins; a line nobody drives is pulled high
  assign pin = (dev_oe & dev_out) | (~dev_oe & ext_en & ext_val) | ~(dev_oe | ext_en);
endmodule

// file: tb/iop_port_ctrl_sva.sv
// concurrent checks on the port control block
`timescale 1ns/1ps
module iop_port_ctrl_sva
  import iop_pkg::*;
#(
  parameter int unsigned NP = 4
)
(
  // clock and reset
  input logic            clk,
  input logic            reset,
  // instruction side
  input logic [3:0]      op,
  input logic [3:0]      acc_in,
  input logic [3:0]      bit_index,
  input logic [3:0]      acc_out,
  input logic            acc_valid,
  // configuration
  input logic [3:0]      port_drive_select_0,
  input logic [3:0]      ext0_control,
  input logic            skip_clear_ext0_flag,
  input logic            pc_latch_in,
  input logic            timer3_out_sel,
  // pins and flag
  input logic [NP*4-1:0] p_in,
  input logic [NP*4-1:0] p_out,
  input logic [NP*4-1:0] p_oe,
  input logic [9:0]      pd_in,
  input logic [9:0]      pd_out,
  input logic [9:0]      pd_oe,
  input logic            pc_out,
  input logic            pc_oe,
  input logic            ext0_request_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_rd_valid; op inside {[IOP_OP_RD_P0:IOP_OP_RD_PD]} |=> acc_valid; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read strobe");
  property p_rd_p0; op == IOP_OP_RD_P0 && $stable(p_in[3:0]) && $stable(p_oe[3:0])
    |=> acc_out == ($past(p_in[3:0]) & ~$past(p_oe[3:0])); endproperty
  a_rd_p0: assert property (p_rd_p0) else $error("p0 read");
  property p_wr_p0; op == IOP_OP_WR_P0 |-> ##2 p_oe[3:0] == (~$past(acc_in, 2)
    | {{2{port_drive_select_0[1]}}, {2{port_drive_select_0[0]}}}); endproperty
  a_wr_p0: assert property (p_wr_p0) else $error("p0 drive");
  property p_wr_p2; op == IOP_OP_WR_P2 |-> ##2 p_oe[11:8] == ~$past(acc_in, 2)
    && (p_out[11:8] & p_oe[11:8]) == 4'h0; endproperty
  a_wr_p2: assert property (p_wr_p2) else $error("p2 drive");
  property p_clr_d8; op == IOP_OP_CLR_D && bit_index == 4'h8 |-> ##2 pd_oe[8] && !pd_out[8];
  endproperty
  a_clr_d8: assert property (p_clr_d8) else $error("d8 drive");
  // a polarity flip alone that leaves the pin mismatching the new polarity must raise the flag
  // the pin must have been steady long enough for the sampled history to match it
  property p_edge; ext0_control[3] && $stable(pd_in[8]) && $changed(ext0_control[2])
    && ($past(pd_in[8]) == $past(pd_in[8], 2))
    && (pd_in[8] ^ ext0_control[2]) |-> ##[1:3] ext0_request_flag; endproperty
  a_edge: assert property (p_edge) else $error("flag not set");
  property p_clear; $fell(ext0_request_flag) |-> $past(skip_clear_ext0_flag); endproperty
  a_clear: assert property (p_clear) else $error("flag lost");
  property p_pc; op == IOP_OP_WR_PC && pc_latch_in && timer3_out_sel |-> ##2 pc_out && pc_oe;
  endproperty
  a_pc: assert property (p_pc) else $error("pc high");
endmodule

// file: tb/iop_port_ctrl_tb.sv
// self-checking bench for the i/o port control block
`timescale 1ns/1ps
module iop_port_ctrl_tb;
  import iop_pkg::*;
  logic        clk, reset, skip_clear_ext0_flag, pc_latch_in, timer3_wave, timer3_out_sel;
  logic [3:0]  op, acc_in, bit_index, ext0_control, pullup_select_0, pullup_select_1;
  logic [3:0]  port_drive_select_0, port_drive_select_1, port_drive_select_2, port_drive_select_3;
  logic [3:0]  acc_out, p4_out, p4_oe;
  logic        acc_valid, test_zero, pc_out, pc_oe, ext0_request_flag;
  logic [15:0] p_out, p_oe;
  logic [9:0]  pd_out, pd_oe;
  logic [7:0]  pullup_en;
  wire  [15:0] p_in;
  wire  [9:0]  pd_in;
  wire  [3:0]  p4_in;
  logic [29:0] ext_en, ext_val;
  int          err_count, num_checks;

  iop_port_ctrl dut_u (.clk, .reset, .op, .acc_in, .bit_index, .acc_out, .acc_valid, .test_zero,
    .port_drive_select_0, .port_drive_select_1, .port_drive_select_2, .port_drive_select_3,
    .ext0_control, .skip_clear_ext0_flag, .pullup_select_0, .pullup_select_1, .p_in, .p_out,
    .p_oe, .p4_out, .p4_oe, .p4_in, .pd_in, .pd_out, .pd_oe, .pc_latch_in, .pc_out, .pc_oe,
    .timer3_wave, .timer3_out_sel, .pullup_en, .ext0_request_flag);
  iop_board brd_u (.dev_out({pd_out, p4_out, p_out}), .dev_oe({pd_oe, p4_oe, p_oe}), .ext_en,
    .ext_val, .pin({pd_in, p4_in, p_in}));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: %h not %h", $time, s, e);
    end
  endtask
  task run_op(input logic [3:0] o, input logic [3:0] a, input logic [3:0] b);
    @(posedge clk);
    #1 op = o;
    acc_in = a;
    bit_index = b;
    @(posedge clk);
    #1 op = IOP_OP_NONE;
  endtask
  // pins follow a write one edge after run_op returns
  task tick;
    @(posedge clk);
    #1;
  endtask

  task t_ports;
    port_drive_select_0 = 4'h1;
    port_drive_select_2 = 4'h5;
    run_op(IOP_OP_WR_P0, 4'hD, 4'h0);
    run_op(IOP_OP_WR_P2, 4'h3, 4'h0);
    run_op(IOP_OP_WR_P4, 4'h6, 4'h0);
    tick;
    // only the level of a driven pin matters; released pins are masked off
    chk({p_oe[3:0], p_out[3:0] & p_oe[3:0]}, 8'h31);
    chk({p_oe[11:8], p_out[11:8] & p_oe[11:8]}, 8'hC0);
    chk({p4_oe, p4_out & p4_oe}, 8'hD4);
    run_op(IOP_OP_RD_P0, 4'h0, 4'h0);
    chk({acc_valid, acc_out}, 5'h14);
    run_op(IOP_OP_RD_P2, 4'h0, 4'h0);
    chk({acc_out, p_oe[3:0]}, 8'h13);
    port_drive_select_0 = 4'h0;
    run_op(IOP_OP_WR_P0, 4'h0, 4'h0);
    tick;
    chk({p_oe[3:0], p_out[3:0]}, 8'hF0);
    $display("port test done");
  endtask

  // ports 1, 3 and 4 reads, pair select on port 1, reads leave latches alone
  task t_reads;
    run_op(IOP_OP_WR_P3, 4'hA, 4'h0);
    run_op(IOP_OP_RD_P3, 4'h0, 4'h0);
    chk(acc_out, 4'hA);
    chk({p_oe[15:12], p_out[15:12] & p_oe[15:12]}, 8'h50);
    run_op(IOP_OP_RD_P4, 4'h0, 4'h0);
    chk(acc_out, 4'h2);
    port_drive_select_0 = 4'h4;
    run_op(IOP_OP_WR_P1, 4'h9, 4'h0);
    tick;
    chk({p_oe[7:4], p_out[7:4] & p_oe[7:4]}, 8'h71);
    run_op(IOP_OP_RD_P1, 4'h0, 4'h0);
    chk({acc_valid, acc_out}, 5'h18);
    chk({p_oe[7:4], p_out[7:4] & p_oe[7:4]}, 8'h71);
    $display("read test done");
  endtask

  task t_pd;
    // bench never powers down, so wakeup bits need no clearing
    ext0_control = 4'h8;
    run_op(IOP_OP_CLR_D, 4'h0, 4'h8);
    run_op(IOP_OP_CLR_D, 4'h0, 4'hA);
    tick;
    chk({pd_oe, pd_out & pd_oe}, 20'h40000);
    run_op(IOP_OP_RD_PD, 4'h0, 4'h0);
    chk(acc_out, 4'h6);
    run_op(IOP_OP_TEST_D, 4'h0, 4'h5);
    chk(test_zero, 1'h1);
    run_op(IOP_OP_TEST_D, 4'h0, 4'h6);
    chk(test_zero, 1'h0);
    port_drive_select_3 = 4'h8;
    run_op(IOP_OP_SET_D, 4'h0, 4'h7);
    tick;
    chk({pd_oe[7], pd_out[7]}, 2'h3);
    skip_clear_ext0_flag = 1'h1;
    tick;
    skip_clear_ext0_flag = 1'h0;
    chk(ext0_request_flag, 1'h0);
    ext0_control = 4'hC;
    repeat (3) tick;
    chk(ext0_request_flag, 1'h1);
    tick;
    skip_clear_ext0_flag = 1'h1;
    tick;
    skip_clear_ext0_flag = 1'h0;
    chk(ext0_request_flag, 1'h0);
    $display("port d test done");
  endtask

  task t_misc;
    timer3_out_sel = 1'h1;
    pc_latch_in = 1'h1;
    pullup_select_0 = 4'h3;
    pullup_select_1 = 4'hC;
    run_op(IOP_OP_WR_PC, 4'h0, 4'h0);
    tick;
    chk({pc_oe, pc_out}, 2'h3);
    chk(pullup_en, 8'hC3);
    $display("misc test done");
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    {reset, skip_clear_ext0_flag, pc_latch_in, timer3_wave, timer3_out_sel} = 5'h10;
    {op, acc_in, bit_index, ext0_control, pullup_select_0, pullup_select_1} = 24'h0;
    {port_drive_select_0, port_drive_select_1, port_drive_select_2, port_drive_select_3} = 16'h0;
    ext_en = 30'h0FF00F0F;
    ext_val = 30'h04600904;
    err_count = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    #1 reset = 1'h0;
    tick;
    chk({pc_oe, p_oe[14:0]}, 16'h8000);
    t_ports;
    t_reads;
    t_pd;
    t_misc;
    finish_test;
  end
endmodule

bind iop_port_ctrl iop_port_ctrl_sva #(.NP(NP)) sva_u (.clk, .reset, .op, .acc_in, .bit_index,
  .acc_out, .acc_valid, .port_drive_select_0, .ext0_control, .skip_clear_ext0_flag, .pc_latch_in,
  .timer3_out_sel, .p_in, .p_out, .p_oe, .pd_in, .pd_out, .pd_oe, .pc_out, .pc_oe,
  .ext0_request_flag);
